/* File: rtl/fic_pkg.sv */
// Constants, message words and types for the information message handler.
// Assumes characters are 8-bit codes and every message is framed by its sender.
//
// Contract
// - Capacity query answered with capacity and count.
// - Capacity field decimal, one to ninety-nine.
// - Stored count from zero to capacity.
// - Name query opens a name listing session.
// - Session opening carries name count, 0-99.
// - Opening, then name records, then session close.
// - Name records only inside an open session.
// - One name per record, 1-16 characters.
// - Session error cause is four characters NREC.
// - Only downstream reports counter relationship.
// - Relationship refers to one reference frame.
// - Frame count of frame carrying reference data.
// - Time is null symbol start of frame.
// - Link frame count of carrying link frame.
// - Frame count field is UU:LLL, bounded.
// - Time field is HH:MM:SS:TTT, bounded.
// - Link count field UU:LLL, high and low.
// - Relationship valid only on synchronous links.
// - Message starts with command and extension words.
package fic_pkg;

	localparam int unsigned CHAR_W = 8; // Bits per character.
	localparam int unsigned HDR_LEN = 11; // Command word, space, extension word.
	localparam int unsigned HDR_W = HDR_LEN * CHAR_W;
	localparam int unsigned ARG_POS = 12; // Index of the first data character.
	localparam int unsigned RX_LEN = 28; // Longest message this block must read.
	localparam int unsigned TX_LEN = 38; // Longest message this block sends.
	localparam int unsigned RX_W = RX_LEN * CHAR_W;
	localparam int unsigned TX_W = TX_LEN * CHAR_W;
	localparam int unsigned NAME_W = 128; // Sixteen name characters.

	localparam logic [7:0] CH_SP = 8'h20; // Field separator.
	localparam logic [7:0] CH_COLON = 8'h3A; // Sub-field separator.
	localparam logic [7:0] CH_ZERO = 8'h30; // Decimal digit zero.

	localparam logic [6:0] CAP_MIN = 7'h01; // Least capacity.
	localparam logic [6:0] CAP_MAX = 7'h63; // Greatest capacity and name count.
	localparam logic [6:0] CNT_SAT = 7'h7F; // Received record counter ceiling.
	localparam logic [4:0] NAME_MIN = 5'h01; // Shortest name.
	localparam logic [4:0] NAME_MAX = 5'h10; // Longest name.
	localparam logic [4:0] UPPER_MAX = 5'h13; // Upper part of a frame count.
	localparam logic [7:0] LOWER_MAX = 8'hF9; // Lower part of a frame count.
	localparam logic [4:0] HOUR_MAX = 5'h17; // Hours.
	localparam logic [5:0] MINSEC_MAX = 6'h3B; // Minutes and seconds.
	localparam logic [9:0] MS_MAX = 10'h3E7; // Milliseconds.

	localparam logic [HDR_W-1:0] HDR_INFO_INF = "FIGINFO INF";
	localparam logic [HDR_W-1:0] HDR_INFO_DEF = "FIGINFO DEF";
	localparam logic [HDR_W-1:0] HDR_NAME_INF = "FIGNAME INF";
	localparam logic [HDR_W-1:0] HDR_NAME_DEF = "FIGNAME DEF";
	localparam logic [HDR_W-1:0] HDR_NAME_REC = "FIGNAME REC";
	localparam logic [HDR_W-1:0] HDR_NAME_END = "FIGNAME END";
	localparam logic [HDR_W-1:0] HDR_NAME_ERR = "FIGNAME ERR";
	localparam logic [HDR_W-1:0] HDR_CNT_INF = "COUNTER INF";
	localparam logic [HDR_W-1:0] HDR_CNT_DEF = "COUNTER DEF";
	localparam logic [31:0] CAUSE_NREC = "NREC";

	localparam logic [5:0] LEN_INFO_DEF = 6'h11; // 17 characters.
	localparam logic [5:0] LEN_NAME_DEF = 6'h0E; // 14 characters.
	localparam logic [5:0] LEN_REC_HDR = 6'h0C; // 12 characters before the name.
	localparam logic [5:0] LEN_END = 6'h0B; // 11 characters.
	localparam logic [5:0] LEN_ERR = 6'h10; // 16 characters.
	localparam logic [5:0] LEN_CNT_DEF = 6'h26; // 38 characters.

	// Main control states.
	typedef enum logic {
		FIC_ST_IDLE = 1'b0,
		FIC_ST_NAMES = 1'b1
	} fic_state_t;

endpackage : fic_pkg

/* File: rtl/fic_tx_if.sv */
// Interface between the message builder and the character serialiser.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface fic_tx_if;
	import fic_pkg::*;
	logic load; // One-cycle request to send text.
	logic [TX_W-1:0] text; // Message, first character in the top byte.
	logic [5:0] len; // Number of characters to send.
	logic busy; // Serialiser still holds a message.
	modport ctl (output load, output text, output len, input busy);
	modport ser (input load, input text, input len, output busy);
endinterface : fic_tx_if

/* File: rtl/fic_tx_ser.sv */
// Character serialiser: shifts a loaded message out one character per accept.
// Assumes the loader only loads while busy is low.
`timescale 1ns/1ps
module fic_tx_ser (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	fic_tx_if.ser tx,
	output logic o_tx_valid,
	output logic [7:0] o_tx_char,
	output logic o_tx_last,
	input wire logic i_tx_ready
);
	import fic_pkg::*;

	// Whole state of the serialiser.
	typedef struct packed {
		logic busy;
		logic [TX_W-1:0] sh;
		logic [5:0] rem;
		logic last;
	} fic_ser_st_t;

	fic_ser_st_t q;
	fic_ser_st_t d;

	// Load latches the text; each accepted character shifts the next one up.
	always_comb begin
		d = q;
		if (!q.busy && tx.load) begin
			d.busy = 1'b1;
			d.sh = tx.text;
			d.rem = tx.len;
			d.last = (tx.len == 6'h01);
		end else if (q.busy && i_tx_ready) begin
			d.sh = q.sh << CHAR_W;
			d.rem = q.rem - 6'h01;
			d.last = (q.rem == 6'h02);
			d.busy = !q.last;
		end
	end

	// State register.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tx.busy = q.busy;
	assign o_tx_valid = q.busy;
	assign o_tx_char = q.sh[TX_W-1 -: CHAR_W];
	assign o_tx_last = q.last;

	// The last flag stands with exactly one remaining character.
	last_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		q.busy |-> (q.last == (q.rem == 6'h01))) else $error("last flag out of step with count");

endmodule : fic_tx_ser

/* File: rtl/fic_msg_handler.sv */
// Information message handler: answers capacity, name listing and counter queries,
// and checks name listing sessions opened by the remote entity.
// Assumes the receive stream, name source and frame counters share i_clk_sys.
`timescale 1ns/1ps
module fic_msg_handler (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_char,
	input wire logic i_rx_last,
	output logic o_rx_ready,
	output logic o_tx_valid,
	output logic [7:0] o_tx_char,
	output logic o_tx_last,
	input wire logic i_tx_ready,
	input wire logic [6:0] i_fig_cap,
	input wire logic [6:0] i_fig_used,
	output logic [6:0] o_name_idx,
	input wire logic [fic_pkg::NAME_W-1:0] i_name_text,
	input wire logic [4:0] i_name_len,
	input wire logic i_link_sync,
	input wire logic i_ref_frame,
	input wire logic i_first_cif_only,
	input wire logic i_ref_first_cif,
	input wire logic [4:0] i_cif_hi,
	input wire logic [7:0] i_cif_lo,
	input wire logic [4:0] i_dfct_hi,
	input wire logic [7:0] i_dfct_lo,
	input wire logic [4:0] i_utc_hour,
	input wire logic [5:0] i_utc_min,
	input wire logic [5:0] i_utc_sec,
	input wire logic [9:0] i_utc_ms,
	output logic o_ref_valid,
	output logic o_nrec_err,
	output logic o_cnt_refused
);
	import fic_pkg::*;

	// Whole state of the handler.
	typedef struct packed {
		fic_state_t st; // Idle or sending a name list.
		logic rdy; // Receive stream may deliver a character.
		logic done; // A whole message waits for decoding.
		logic [5:0] rx_cnt; // Characters kept of the current message.
		logic [RX_W-1:0] rx_buf; // Received message, first character on top.
		logic [6:0] nrec; // Names announced in our own session.
		logic [6:0] idx; // Next name to send.
		logic rx_open; // Remote name session is open.
		logic [6:0] rx_exp; // Names the remote entity announced.
		logic [6:0] rx_got; // Names received so far.
		logic ref_ok; // Reference snapshot is usable.
		logic [4:0] cif_hi; // Snapshot of the frame count.
		logic [7:0] cif_lo;
		logic [4:0] dfct_hi; // Snapshot of the link frame count.
		logic [7:0] dfct_lo;
		logic [4:0] hour; // Snapshot of the null symbol time.
		logic [5:0] min;
		logic [5:0] sec;
		logic [9:0] ms;
		logic err; // Pulse: session error sent.
		logic refused; // Pulse: counter query refused.
	} fic_main_st_t;

	fic_main_st_t q;
	fic_main_st_t d;

	fic_tx_if tx ();

	logic ld; // Load the serialiser this cycle.
	logic ld_rec; // The load carries a name record.
	logic ld_cnt; // The load carries the counter report.
	logic [TX_W-1:0] txt; // Text to load.
	logic [5:0] tl; // Its length.
	logic rx_fire; // A character is accepted.
	logic [HDR_W-1:0] hdr; // Command and extension of the held message.
	logic [6:0] cap_c; // Capacity forced into its legal range.
	logic [6:0] used_c; // Stored count, never above capacity.
	logic [4:0] name_len_c; // Name length forced into its legal range.

	// Two decimal digits of a value up to 99; a leading zero keeps fields fixed width.
	function automatic logic [15:0] fic_dec2(input logic [6:0] v);
		logic [6:0] t;
		t = v / 7'h0A;
		return {CH_ZERO + 8'(t), CH_ZERO + 8'(v - t * 7'h0A)};
	endfunction : fic_dec2

	// Three decimal digits of a value up to 999.
	function automatic logic [23:0] fic_dec3(input logic [9:0] v);
		logic [9:0] h;
		logic [9:0] r;
		h = v / 10'h064;
		r = v - h * 10'h064;
		return {CH_ZERO + 8'(h), fic_dec2(7'(r))};
	endfunction : fic_dec3

	// Value of one decimal character.
	function automatic logic [6:0] fic_digit(input logic [7:0] c);
		return 7'(c - CH_ZERO);
	endfunction : fic_digit

	// Moves a short message to the top of the text word.
	function automatic logic [TX_W-1:0] fic_align(input logic [TX_W-1:0] v, input logic [5:0] n);
		return v << ((TX_LEN - int'(n)) * CHAR_W);
	endfunction : fic_align

	assign hdr = q.rx_buf[RX_W-1 -: HDR_W];
	assign rx_fire = i_rx_valid && q.rdy;

	// Clamp the reported numbers so a misbehaving store cannot send an illegal field.
	always_comb begin
		cap_c = i_fig_cap;
		if (i_fig_cap < CAP_MIN) begin
			cap_c = CAP_MIN;
		end else if (i_fig_cap > CAP_MAX) begin
			cap_c = CAP_MAX;
		end
		used_c = (i_fig_used > cap_c) ? cap_c : i_fig_used;
		name_len_c = i_name_len;
		if (i_name_len < NAME_MIN) begin
			name_len_c = NAME_MIN;
		end else if (i_name_len > NAME_MAX) begin
			name_len_c = NAME_MAX;
		end
	end

	// Next-state logic: reception, reference snapshot, decoding and sending.
	always_comb begin
		d = q;
		ld = 1'b0;
		ld_rec = 1'b0;
		ld_cnt = 1'b0;
		txt = '0;
		tl = '0;
		d.err = 1'b0;
		d.refused = 1'b0;

		// Snapshot of one reference frame; in the first-CIF modes only the first CIF counts.
		if (i_ref_frame && (!i_first_cif_only || i_ref_first_cif)) begin
			d.ref_ok = 1'b1;
			d.cif_hi = (i_cif_hi > UPPER_MAX) ? UPPER_MAX : i_cif_hi;
			d.cif_lo = (i_cif_lo > LOWER_MAX) ? LOWER_MAX : i_cif_lo;
			d.dfct_hi = (i_dfct_hi > UPPER_MAX) ? UPPER_MAX : i_dfct_hi;
			d.dfct_lo = (i_dfct_lo > LOWER_MAX) ? LOWER_MAX : i_dfct_lo;
			d.hour = (i_utc_hour > HOUR_MAX) ? HOUR_MAX : i_utc_hour;
			d.min = (i_utc_min > MINSEC_MAX) ? MINSEC_MAX : i_utc_min;
			d.sec = (i_utc_sec > MINSEC_MAX) ? MINSEC_MAX : i_utc_sec;
			d.ms = (i_utc_ms > MS_MAX) ? MS_MAX : i_utc_ms;
		end
		// Losing synchronism spoils the snapshot, even one taken this cycle.
		if (!i_link_sync) begin
			d.ref_ok = 1'b0;
		end

		// Characters past the longest known message are dropped; the header still decodes.
		if (rx_fire) begin
			if (int'(q.rx_cnt) < RX_LEN) begin
				d.rx_buf[RX_W - 1 - int'(q.rx_cnt) * CHAR_W -: CHAR_W] = i_rx_char;
				d.rx_cnt = q.rx_cnt + 6'h01;
			end
			if (i_rx_last) begin
				d.done = 1'b1;
			end
		end

		unique case (q.st)
			FIC_ST_IDLE: begin
				// Decode only when the serialiser is free, so any answer loads at once.
				if (q.done && !tx.busy) begin
					d.done = 1'b0;
					d.rx_cnt = '0;
					d.rx_buf = '0;
					if (hdr == HDR_INFO_INF) begin
						ld = 1'b1;
						txt = fic_align(TX_W'({HDR_INFO_DEF, CH_SP, fic_dec2(cap_c), CH_SP, fic_dec2(used_c)}),
							LEN_INFO_DEF);
						tl = LEN_INFO_DEF;
					end else if (hdr == HDR_NAME_INF) begin
						// Open our own session announcing every stored name.
						ld = 1'b1;
						txt = fic_align(TX_W'({HDR_NAME_DEF, CH_SP, fic_dec2(used_c)}), LEN_NAME_DEF);
						tl = LEN_NAME_DEF;
						d.nrec = used_c;
						d.idx = '0;
						d.st = FIC_ST_NAMES;
					end else if (hdr == HDR_NAME_DEF) begin
						// Remote session opens; a lone digit means a one-character count.
						d.rx_open = 1'b1;
						d.rx_got = '0;
						if (int'(q.rx_cnt) == ARG_POS + 1) begin
							d.rx_exp = fic_digit(q.rx_buf[RX_W - 1 - ARG_POS * CHAR_W -: CHAR_W]);
						end else begin
							d.rx_exp = 7'(fic_digit(q.rx_buf[RX_W - 1 - ARG_POS * CHAR_W -: CHAR_W]) * 7'h0A
								+ fic_digit(q.rx_buf[RX_W - 1 - (ARG_POS + 1) * CHAR_W -: CHAR_W]));
						end
					end else if (hdr == HDR_NAME_REC) begin
						// A record outside a session changes nothing.
						if (q.rx_open && q.rx_got != CNT_SAT) begin
							d.rx_got = q.rx_got + 7'h01;
						end
					end else if (hdr == HDR_NAME_END) begin
						if (q.rx_open) begin
							d.rx_open = 1'b0;
							if (q.rx_got != q.rx_exp) begin
								ld = 1'b1;
								txt = fic_align(TX_W'({HDR_NAME_ERR, CH_SP, CAUSE_NREC}), LEN_ERR);
								tl = LEN_ERR;
								d.err = 1'b1;
							end
						end
					end else if (hdr == HDR_CNT_INF) begin
						// The report is only meaningful on a synchronous link.
						if (q.ref_ok && i_link_sync) begin
							ld = 1'b1;
							ld_cnt = 1'b1;
							txt = {HDR_CNT_DEF, CH_SP,
								fic_dec2(7'(q.cif_hi)), CH_COLON, fic_dec3(10'(q.cif_lo)), CH_SP,
								fic_dec2(7'(q.hour)), CH_COLON, fic_dec2(7'(q.min)), CH_COLON,
								fic_dec2(7'(q.sec)), CH_COLON, fic_dec3(q.ms), CH_SP,
								fic_dec2(7'(q.dfct_hi)), CH_COLON, fic_dec3(10'(q.dfct_lo))};
							tl = LEN_CNT_DEF;
						end else begin
							d.refused = 1'b1;
						end
					end
				end
			end
			FIC_ST_NAMES: begin
				// One record per stored name, then the close; each waits for the serialiser.
				if (!tx.busy) begin
					if (q.idx == q.nrec) begin
						ld = 1'b1;
						txt = fic_align(TX_W'(HDR_NAME_END), LEN_END);
						tl = LEN_END;
						d.st = FIC_ST_IDLE;
					end else begin
						ld = 1'b1;
						ld_rec = 1'b1;
						txt = fic_align(TX_W'({HDR_NAME_REC, CH_SP, i_name_text}), LEN_REC_HDR + 6'(NAME_MAX));
						tl = LEN_REC_HDR + 6'(name_len_c);
						d.idx = q.idx + 7'h01;
					end
				end
			end
		endcase

		// Stop the stream while a message waits or a list is being sent.
		d.rdy = (d.st == FIC_ST_IDLE) && !d.done;
	end

	// State register.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tx.load = ld;
	assign tx.text = txt;
	assign tx.len = tl;

	// The serialiser owns the outgoing character stream.
	fic_tx_ser u_ser (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.tx(tx),
		.o_tx_valid(o_tx_valid),
		.o_tx_char(o_tx_char),
		.o_tx_last(o_tx_last),
		.i_tx_ready(i_tx_ready)
	);

	assign o_rx_ready = q.rdy;
	assign o_name_idx = q.idx;
	assign o_ref_valid = q.ref_ok;
	assign o_nrec_err = q.err;
	assign o_cnt_refused = q.refused;

	default clocking fic_cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	// A capacity query starts an answer on the next cycle.
	info_reply_a: assert property (
		(q.st == FIC_ST_IDLE && q.done && !tx.busy && hdr == HDR_INFO_INF) |=> tx.busy ##0 o_tx_valid)
		else $error("capacity query not answered");

	// Reported capacity stays within its range.
	cap_range_a: assert property ((cap_c >= CAP_MIN) && (cap_c <= CAP_MAX))
		else $error("capacity out of range");

	// Reported stored count never exceeds capacity.
	used_range_a: assert property (used_c <= cap_c)
		else $error("stored count above capacity");

	// Announced name count stays within 0..99 for the whole session.
	nrec_range_a: assert property (q.st == FIC_ST_NAMES |-> q.nrec <= CAP_MAX && q.idx <= q.nrec)
		else $error("name count out of range");

	// Name records are loaded only inside our own session.
	rec_session_a: assert property (ld_rec |-> q.st == FIC_ST_NAMES)
		else $error("name record outside session");

	// A record carries between one and sixteen name characters.
	rec_length_a: assert property (ld_rec |-> (tl > LEN_REC_HDR) && (tl <= LEN_REC_HDR + 6'(NAME_MAX)))
		else $error("name record length illegal");

	// After the last record the close goes out and the session ends.
	list_close_a: assert property (
		(q.st == FIC_ST_NAMES && !tx.busy && q.idx == q.nrec) |-> ld ##1 (q.st == FIC_ST_IDLE) && tx.busy)
		else $error("name session not closed");

	// A wrong record count at close raises the error pulse for exactly one cycle.
	nrec_error_a: assert property (
		(q.st == FIC_ST_IDLE && q.done && !tx.busy && hdr == HDR_NAME_END && q.rx_open && q.rx_got != q.rx_exp)
		|=> o_nrec_err ##1 !o_nrec_err)
		else $error("record count error missed");

	// A stray record leaves session state untouched.
	rec_discard_a: assert property (
		(q.st == FIC_ST_IDLE && q.done && !tx.busy && hdr == HDR_NAME_REC && !q.rx_open)
		|=> !q.rx_open && $stable(q.rx_got))
		else $error("stray record changed session");

	// The counter report goes out only from a valid snapshot on a synchronous link.
	counter_sync_a: assert property (ld_cnt |-> i_link_sync && q.ref_ok)
		else $error("counter report without synchronism");

	// An accepted reference frame is captured on the next edge.
	ref_capture_a: assert property (
		(i_ref_frame && (!i_first_cif_only || i_ref_first_cif) && i_link_sync && i_cif_lo <= LOWER_MAX)
		|=> q.ref_ok && q.cif_lo == $past(i_cif_lo))
		else $error("reference frame not captured");

endmodule : fic_msg_handler

/* File: tb/fic_remote.sv */
// Model of the remote broadcast entity on the far side of the message stream.
// Assumes one shared clock; it drives its outputs at the falling edge only.
`timescale 1ns/1ps
module fic_remote (
	input wire logic i_clk_sys,
	input wire logic i_rx_ready,
	output logic o_rx_valid,
	output logic [7:0] o_rx_char,
	output logic o_rx_last,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_char,
	input wire logic i_tx_last,
	output logic o_tx_ready,
	input wire logic i_slow
);
	string cur; // Reply being gathered.
	string got[$]; // Completed replies, oldest first.

	// Idle lines start quiet; the sink begins by stalling.
	initial begin
		o_rx_valid = 1'b0;
		o_rx_char = 8'hA5;
		o_rx_last = 1'b0;
		o_tx_ready = 1'b0;
		cur = "";
	end

	// In slow mode the sink accepts every other cycle, so replies must hold.
	always @(negedge i_clk_sys) begin
		o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
	end

	// Gather reply characters into whole messages at each accepted edge.
	always @(posedge i_clk_sys) begin
		if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) begin
			cur = {cur, string'(i_tx_char)};
			if (i_tx_last === 1'b1) begin
				got.push_back(cur);
				cur = "";
			end
		end
	end

	// Sends one framed message; each character holds until an edge with ready high.
	task automatic send(input string s);
		int i;
		for (i = 0; i < s.len(); i++) begin
			@(negedge i_clk_sys);
			o_rx_valid = 1'b1;
			o_rx_char = s[i];
			o_rx_last = (i == s.len() - 1);
			while (i_rx_ready !== 1'b1) @(negedge i_clk_sys);
			@(posedge i_clk_sys);
		end
		@(negedge i_clk_sys);
		o_rx_valid = 1'b0;
		o_rx_last = 1'b0;
		o_rx_char = ~o_rx_char; // A released line must not keep its last value.
	endtask : send
endmodule : fic_remote

/* File: tb/tb.sv */
// Self-checking bench for the information message handler.
// Assumes the remote model in fic_remote.sv and the handler's package.
`timescale 1ns/1ps
module tb;
	import fic_pkg::*;
	logic clk, rst_n, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, slow;
	logic [7:0] rx_char, tx_char, cif_lo, dfct_lo;
	logic [6:0] cap, used, name_idx;
	logic [NAME_W-1:0] name_text;
	logic [4:0] name_len, cif_hi, dfct_hi, hour;
	logic sync, ref_frame, first_only, ref_first, ref_valid, nrec_err, cnt_refused;
	logic [5:0] mins, secs;
	logic [9:0] ms;
	int error_cnt = 0;
	int n_compared = 0;
	int nrec_n = 0; // Error pulses seen.
	int refuse_n = 0; // Refusal pulses seen.

	// Name source: a short name at index 0, a full sixteen-character one after.
	assign name_text = (name_idx == 7'h00) ? {"F0", {14{8'h20}}} : "ABCDEFGHIJKLMNOP";
	assign name_len = (name_idx == 7'h00) ? 5'h02 : 5'h10;

	fic_msg_handler dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_rx_valid(rx_valid),
		.i_rx_char(rx_char), .i_rx_last(rx_last), .o_rx_ready(rx_ready),
		.o_tx_valid(tx_valid), .o_tx_char(tx_char), .o_tx_last(tx_last),
		.i_tx_ready(tx_ready), .i_fig_cap(cap), .i_fig_used(used), .o_name_idx(name_idx),
		.i_name_text(name_text), .i_name_len(name_len), .i_link_sync(sync),
		.i_ref_frame(ref_frame), .i_first_cif_only(first_only), .i_ref_first_cif(ref_first),
		.i_cif_hi(cif_hi), .i_cif_lo(cif_lo), .i_dfct_hi(dfct_hi), .i_dfct_lo(dfct_lo),
		.i_utc_hour(hour), .i_utc_min(mins), .i_utc_sec(secs), .i_utc_ms(ms),
		.o_ref_valid(ref_valid), .o_nrec_err(nrec_err), .o_cnt_refused(cnt_refused));

	fic_remote rem (.i_clk_sys(clk), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid),
		.o_rx_char(rx_char), .o_rx_last(rx_last), .i_tx_valid(tx_valid),
		.i_tx_char(tx_char), .i_tx_last(tx_last), .o_tx_ready(tx_ready), .i_slow(slow));

	// Clock of 4 ns period.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// One-cycle pulses are counted here so that no scenario can miss them.
	always @(posedge clk) begin
		if (nrec_err === 1'b1) nrec_n <= nrec_n + 1;
		if (cnt_refused === 1'b1) refuse_n <= refuse_n + 1;
	end

	task automatic conclude();
		$display("error_cnt=%0d n_compared=%0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude

	task automatic chk(input bit ok, input string what);
		n_compared++;
		if (!ok) begin
			error_cnt++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask : chk

	// Waits a bounded time for the next reply and compares it whole.
	task automatic expect_msg(input string exp);
		int k;
		string got;
		k = 0;
		while (rem.got.size() == 0 && k < 2000) begin
			@(negedge clk);
			k++;
		end
		got = (rem.got.size() == 0) ? "(none)" : rem.got.pop_front();
		chk(got == exp, {"reply ", got, " wanted ", exp});
	endtask : expect_msg

	task automatic expect_none();
		repeat (100) @(negedge clk);
		chk(rem.got.size() == 0, "reply where none is due");
	endtask : expect_none

	task automatic pulse_ref();
		@(negedge clk);
		ref_frame = 1'b1;
		@(negedge clk);
		ref_frame = 1'b0;
		repeat (3) @(negedge clk);
	endtask : pulse_ref

	// Capacity query: clamping at both ends and the used-equals-capacity boundary.
	task automatic t_info();
		cap = 7'h78;
		used = 7'h05;
		rem.send("FIGINFO INF");
		expect_msg("FIGINFO DEF 99 05");
		cap = 7'h00;
		used = 7'h03;
		rem.send("FIGINFO INF");
		expect_msg("FIGINFO DEF 01 01");
		cap = 7'h0C;
		used = 7'h0C;
		rem.send("FIGINFO INF");
		expect_msg("FIGINFO DEF 12 12");
	endtask : t_info

	// Name listing against a stalling sink, then an empty listing.
	task automatic t_names();
		slow = 1'b1;
		used = 7'h02;
		rem.send("FIGNAME INF");
		expect_msg("FIGNAME DEF 02");
		expect_msg("FIGNAME REC F0");
		expect_msg("FIGNAME REC ABCDEFGHIJKLMNOP");
		expect_msg("FIGNAME END");
		slow = 1'b0;
		used = 7'h00;
		rem.send("FIGNAME INF");
		expect_msg("FIGNAME DEF 00");
		expect_msg("FIGNAME END");
	endtask : t_names

	// Remote sessions: a stray record is dropped, one- and two-digit counts pass, a short count is reported.
	task automatic t_session();
		rem.send("FIGNAME REC STRAY");
		rem.send("FIGNAME DEF 1");
		rem.send("FIGNAME REC A");
		rem.send("FIGNAME END");
		rem.send("FIGNAME DEF 02");
		rem.send("FIGNAME REC A");
		rem.send("FIGNAME REC B");
		rem.send("FIGNAME END");
		expect_none();
		chk(nrec_n == 0, "error pulse on a good session");
		rem.send("FIGNAME DEF 2");
		rem.send("FIGNAME REC A");
		rem.send("FIGNAME END");
		expect_msg("FIGNAME ERR NREC");
		chk(nrec_n == 1, "error pulse count");
	endtask : t_session

	// Counter relation: refusals, first-CIF gating, capture, field clamping, loss of sync.
	task automatic t_counter();
		rem.send("COUNTER INF");
		expect_none();
		chk(refuse_n == 1, "no refusal without snapshot");
		first_only = 1'b1;
		ref_first = 1'b0;
		pulse_ref();
		chk(ref_valid === 1'b0, "capture outside first CIF");
		ref_first = 1'b1;
		pulse_ref();
		chk(ref_valid === 1'b1, "snapshot not taken");
		cif_hi = 5'h1F;
		rem.send("COUNTER INF");
		expect_msg("COUNTER DEF 07:123 12:34:56:789 19:249");
		cif_lo = 8'hFF;
		dfct_lo = 8'hFE;
		hour = 5'h1F;
		ms = 10'h3FF;
		pulse_ref();
		rem.send("COUNTER INF");
		expect_msg("COUNTER DEF 19:249 23:34:56:999 19:249");
		sync = 1'b0;
		repeat (3) @(negedge clk);
		chk(ref_valid === 1'b0, "snapshot kept on async link");
		rem.send("COUNTER INF");
		expect_none();
		chk(refuse_n == 2, "no refusal on async link");
	endtask : t_counter

	// Main sequence: quiet inputs, five cycles of reset, then every scenario.
	initial begin
		rst_n = 1'b0;
		slow = 1'b0;
		cap = 7'h01;
		used = 7'h00;
		sync = 1'b1;
		ref_frame = 1'b0;
		first_only = 1'b0;
		ref_first = 1'b0;
		cif_hi = 5'h07;
		cif_lo = 8'h7B;
		dfct_hi = 5'h13;
		dfct_lo = 8'hF9;
		hour = 5'h0C;
		mins = 6'h22;
		secs = 6'h38;
		ms = 10'h315;
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_info();
		t_names();
		t_session();
		t_counter();
		conclude();
	end

	// Watchdog: the scenarios need some thousand cycles at most.
	initial begin
		#100000;
		error_cnt++;
		conclude();
	end
endmodule : tb
